// file: rtl/crf_top.sv
// Architectural register set of the core: pointers, banks, status word, stack.
// Assumes the execution datapath drives one-cycle request pulses synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none

module crf_top (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_rd,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_bit_wr,
  input  wire logic [2:0]  sfr_bit_idx,
  input  wire logic        sfr_bit_val,
  output logic      [7:0]  sfr_rdata_q,
  // Datapath results
  input  wire logic        acc_wr,
  input  wire logic [7:0]  acc_wdata,
  input  wire logic        b_wr,
  input  wire logic [7:0]  b_wdata,
  input  wire logic        flag_upd,
  input  wire logic [1:0]  flag_op,
  input  wire logic        flag_cy,
  input  wire logic        flag_ac,
  input  wire logic        flag_ov,
  // Pointer operations
  input  wire logic        ptr_load,
  input  wire logic [15:0] ptr_load_val,
  input  wire logic        ptr_inc,
  // Stack
  input  wire logic        push,
  input  wire logic [7:0]  push_data,
  input  wire logic        pop,
  // Working registers and address windows
  input  wire logic        wreg_rd,
  input  wire logic        wreg_wr,
  input  wire logic [2:0]  wreg_idx,
  input  wire logic [7:0]  wreg_wdata,
  input  wire logic        xd_req,
  input  wire logic        xd_wr,
  input  wire logic [15:0] xd_addr,
  input  wire logic [7:0]  xd_wdata,
  input  wire logic        ind_req,
  input  wire logic        ind_sel,
  input  wire logic        dir_req,
  input  wire logic [7:0]  dir_addr,
  // Branch targets
  input  wire logic        tgt_req,
  input  wire logic [1:0]  tgt_kind,
  input  wire logic [15:0] next_pc,
  input  wire logic [15:0] tgt_off,
  // Results
  output logic      [7:0]  ram_rdata_q,
  output logic             ram_rvld_q,
  output logic      [15:0] dptr_q,
  output logic      [7:0]  psw_q,
  output logic      [7:0]  acc_q,
  output logic      [7:0]  b_q,
  output logic      [7:0]  sp_q,
  output logic      [1:0]  bank_q,
  output logic      [7:0]  ind_addr_q,
  output logic             ind_vld_q,
  output logic      [7:0]  dir_addr_q,
  output logic             dir_is_sfr_q,
  output logic             dir_is_ram_q,
  output logic             stk_wr_q,
  output logic             stk_rd_q,
  output logic      [7:0]  stk_addr_q,
  output logic      [7:0]  stk_data_q,
  output logic      [15:0] tgt_pc_q,
  output logic             tgt_vld_q
);

  typedef struct packed {
    logic [7:0]  sp;
    logic [7:0]  pointer0_low_byte;
    logic [7:0]  pointer0_high_byte;
    logic [7:0]  pointer1_low_byte;
    logic [7:0]  pointer1_high_byte;
    logic        pointer_select;
    logic [7:0]  processor_status_word;
    logic [7:0]  acc;
    logic [7:0]  b;
    logic [7:0]  rdata;
    logic [15:0] dptr;
    logic [1:0]  bank;
    logic        rvld;
    logic        ind_pend;
    logic [7:0]  ind_addr;
    logic        ind_vld;
    logic [7:0]  dir_addr;
    logic        dir_sfr;
    logic        dir_ram;
    logic        stk_wr;
    logic        stk_rd;
    logic [7:0]  stk_addr;
    logic [7:0]  stk_data;
    logic [15:0] tgt;
    logic        tgt_vld;
  } crf_state_t;

  crf_state_t st_q;
  crf_state_t st_d;
  logic [1:0] rsync_q;
  logic       rst_n_q;
  logic       mem_we;
  logic [4:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [7:0] sp_inc;
  logic       xd_hit;

  // Address of register idx in the given bank: bank n covers 8n..8n+7
  function automatic logic [4:0] wreg_addr(input logic [1:0] bank, input logic [2:0] idx);
    wreg_addr = {bank, idx};
  endfunction

  // Byte view of a register, shared by read-back and read-modify bit writes
  function automatic logic [7:0] sfr_view(input crf_state_t s, input logic [7:0] a);
    case (a)
      crf_pkg::OFS_STACK_POINTER:  sfr_view = s.sp;
      crf_pkg::OFS_PTR0_LOW:       sfr_view = s.pointer0_low_byte;
      crf_pkg::OFS_PTR0_HIGH:      sfr_view = s.pointer0_high_byte;
      crf_pkg::OFS_PTR1_LOW:       sfr_view = s.pointer1_low_byte;
      crf_pkg::OFS_PTR1_HIGH:      sfr_view = s.pointer1_high_byte;
      crf_pkg::OFS_POINTER_SELECT: sfr_view = {7'h00, s.pointer_select};
      crf_pkg::OFS_STATUS_WORD:    sfr_view = s.processor_status_word;
      crf_pkg::OFS_ACCUMULATOR:    sfr_view = s.acc;
      crf_pkg::OFS_MULDIV_OPERAND: sfr_view = s.b;
      default:                     sfr_view = 8'h00;
    endcase
  endfunction

  // ==========================================================================
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rsync_q <= 2'h0;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n_q = rsync_q[1];

  // ==========================================================================
  // Working-register memory port; one access a cycle, push has priority
  assign sp_inc = st_q.sp + 8'h01;
  assign xd_hit = (xd_addr >= crf_pkg::XWIN_FIRST) && (xd_addr <= crf_pkg::XWIN_LAST);

  always_comb begin
    mem_we    = 1'b0;
    mem_wdata = 8'h00;
    mem_addr  = wreg_addr(st_q.bank, wreg_idx);
    if (push && (sp_inc[7:5] == 3'h0)) begin
      mem_we    = 1'b1;
      mem_addr  = sp_inc[4:0];
      mem_wdata = push_data;
    end else if (wreg_wr) begin
      mem_we    = 1'b1;
      mem_wdata = wreg_wdata;
    end else if (xd_req && xd_hit) begin
      mem_we    = xd_wr;
      mem_addr  = xd_addr[4:0];
      mem_wdata = xd_wdata;
    end else if (ind_req) begin
      mem_addr  = wreg_addr(st_q.bank, {2'h0, ind_sel});
    end
  end

  crf_wreg_ram u_ram (
    .clk_sys (clk_sys),
    .rst_n   (rst_n_q),
    .clk_en  (clk_en),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (mem_wdata),
    .rdata_q (mem_rdata)
  );

  // ==========================================================================
  // Register state: datapath effects first, software writes override
  always_comb begin
    logic [7:0] v;
    v             = 8'h00;
    st_d          = st_q;
    st_d.stk_wr   = 1'b0;
    st_d.stk_rd   = 1'b0;
    st_d.ind_vld  = 1'b0;
    st_d.tgt_vld  = 1'b0;
    st_d.rvld     = !mem_we && (wreg_rd || (xd_req && xd_hit) || ind_req);
    // Indirect fetch outranks a plain register read, so it must not be dropped by one
    st_d.ind_pend = !mem_we && !(xd_req && xd_hit) && ind_req;
    // Indirect address becomes the register contents one cycle after the read
    if (st_q.ind_pend) begin
      st_d.ind_addr = mem_rdata;
      st_d.ind_vld  = 1'b1;
    end
    if (acc_wr) begin
      st_d.acc = acc_wdata;
    end
    if (b_wr) begin
      st_d.b = b_wdata;
    end
    // Arithmetic flags; carry kinds only count for add and subtract
    if (flag_upd) begin
      st_d.processor_status_word[crf_pkg::PSW_CARRY] = flag_cy && (flag_op == crf_pkg::FOP_ADD ||
                                                 flag_op == crf_pkg::FOP_SUB);
      st_d.processor_status_word[crf_pkg::PSW_NIBBLE_CARRY] = flag_ac && (flag_op == crf_pkg::FOP_ADD ||
                                                        flag_op == crf_pkg::FOP_SUB);
      st_d.processor_status_word[crf_pkg::PSW_OVERFLOW] = flag_ov && (flag_op != crf_pkg::FOP_OTHER);
    end
    // Active pointer load or increment
    if (ptr_load || ptr_inc) begin
      if (st_q.pointer_select) begin
        {st_d.pointer1_high_byte, st_d.pointer1_low_byte} = ptr_load ? ptr_load_val : {st_q.pointer1_high_byte, st_q.pointer1_low_byte} + 16'h0001;
      end else begin
        {st_d.pointer0_high_byte, st_d.pointer0_low_byte} = ptr_load ? ptr_load_val : {st_q.pointer0_high_byte, st_q.pointer0_low_byte} + 16'h0001;
      end
    end
    // Stack: pre-increment on push, post-decrement on pop
    if (push) begin
      st_d.sp       = sp_inc;
      st_d.stk_wr   = 1'b1;
      st_d.stk_addr = sp_inc;
      st_d.stk_data = push_data;
    end else if (pop) begin
      st_d.sp       = st_q.sp - 8'h01;
      st_d.stk_rd   = 1'b1;
      st_d.stk_addr = st_q.sp;
    end
    // Software byte and bit writes win over datapath updates
    if (sfr_wr || sfr_bit_wr) begin
      v = sfr_wdata;
      if (!sfr_wr) begin
        v = sfr_view(st_d, sfr_addr);
        v[sfr_bit_idx] = sfr_bit_val;
      end
      case (sfr_addr)
        crf_pkg::OFS_STACK_POINTER:  st_d.sp = v;
        crf_pkg::OFS_PTR0_LOW:       st_d.pointer0_low_byte = v;
        crf_pkg::OFS_PTR0_HIGH:      st_d.pointer0_high_byte = v;
        crf_pkg::OFS_PTR1_LOW:       st_d.pointer1_low_byte = v;
        crf_pkg::OFS_PTR1_HIGH:      st_d.pointer1_high_byte = v;
        crf_pkg::OFS_POINTER_SELECT: st_d.pointer_select = v[0];
        crf_pkg::OFS_STATUS_WORD:    st_d.processor_status_word = v;
        crf_pkg::OFS_ACCUMULATOR:    st_d.acc = v;
        crf_pkg::OFS_MULDIV_OPERAND: st_d.b = v;
        default:                     st_d.pointer_select = st_d.pointer_select;
      endcase
    end
    // Parity always follows the accumulator; a written parity bit does not stick
    st_d.processor_status_word[crf_pkg::PSW_PARITY] = ^st_d.acc;
    st_d.bank = st_d.processor_status_word[crf_pkg::PSW_BANK_HI:crf_pkg::PSW_BANK_LO];
    st_d.dptr = st_d.pointer_select ? {st_d.pointer1_high_byte, st_d.pointer1_low_byte} : {st_d.pointer0_high_byte, st_d.pointer0_low_byte};
    if (sfr_rd) begin
      st_d.rdata = sfr_view(st_q, sfr_addr);
    end
    // Direct operand routing by address half
    if (dir_req) begin
      st_d.dir_addr = dir_addr;
      st_d.dir_sfr  = (dir_addr >= crf_pkg::DIRECT_SFR_FIRST);
      st_d.dir_ram  = (dir_addr <  crf_pkg::DIRECT_SFR_FIRST);
    end
    // Branch target formation
    if (tgt_req) begin
      st_d.tgt_vld = 1'b1;
      case (tgt_kind)
        crf_pkg::TGT_PAGE: st_d.tgt = {next_pc[15:crf_pkg::PAGE_BITS],
                                       tgt_off[crf_pkg::PAGE_BITS-1:0]};
        crf_pkg::TGT_REL:  st_d.tgt = next_pc + {{8{tgt_off[7]}}, tgt_off[7:0]};
        default:           st_d.tgt = tgt_off;
      endcase
    end
  end

  // Whole state frozen while the clock enable is low
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q    <= '0;
      st_q.sp <= crf_pkg::RST_STACK_POINTER;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flops
  assign sfr_rdata_q  = st_q.rdata;
  assign ram_rdata_q  = mem_rdata;
  assign ram_rvld_q   = st_q.rvld;
  assign dptr_q       = st_q.dptr;
  assign psw_q        = st_q.processor_status_word;
  assign acc_q        = st_q.acc;
  assign b_q          = st_q.b;
  assign sp_q         = st_q.sp;
  assign bank_q       = st_q.bank;
  assign ind_addr_q   = st_q.ind_addr;
  assign ind_vld_q    = st_q.ind_vld;
  assign dir_addr_q   = st_q.dir_addr;
  assign dir_is_sfr_q = st_q.dir_sfr;
  assign dir_is_ram_q = st_q.dir_ram;
  assign stk_wr_q     = st_q.stk_wr;
  assign stk_rd_q     = st_q.stk_rd;
  assign stk_addr_q   = st_q.stk_addr;
  assign stk_data_q   = st_q.stk_data;
  assign tgt_pc_q     = st_q.tgt;
  assign tgt_vld_q    = st_q.tgt_vld;

  // ==========================================================================
  // Checks
  property p_push_addr;
    @(posedge clk_sys) disable iff (!rst_n_q)
    (clk_en && push) |=> (stk_wr_q && stk_addr_q == $past(sp_q) + 8'h01 && sp_q == stk_addr_q);
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("push address wrong");

  property p_parity;
    @(posedge clk_sys) disable iff (!rst_n_q)
    psw_q[crf_pkg::PSW_PARITY] == ^acc_q;
  endproperty
  a_parity: assert property (p_parity) else $error("parity mismatch");

  property p_dps_read;
    @(posedge clk_sys) disable iff (!rst_n_q)
    (clk_en && sfr_rd && sfr_addr == crf_pkg::OFS_POINTER_SELECT)
      |=> (sfr_rdata_q[7:1] == 7'h00 && sfr_rdata_q[0] == $past(st_q.pointer_select));
  endproperty
  a_dps_read: assert property (p_dps_read) else $error("select read wrong");

  property p_ptr_sel;
    @(posedge clk_sys) disable iff (!rst_n_q)
    dptr_q == (st_q.pointer_select ? {st_q.pointer1_high_byte, st_q.pointer1_low_byte} : {st_q.pointer0_high_byte, st_q.pointer0_low_byte});
  endproperty
  a_ptr_sel: assert property (p_ptr_sel) else $error("active pointer wrong");

  property p_carry_add;
    @(posedge clk_sys) disable iff (!rst_n_q)
    (clk_en && flag_upd && flag_op == crf_pkg::FOP_ADD && !sfr_wr && !sfr_bit_wr)
      |=> psw_q[crf_pkg::PSW_CARRY] == $past(flag_cy);
  endproperty
  a_carry_add: assert property (p_carry_add) else $error("carry not taken");

  property p_dir_split;
    @(posedge clk_sys) disable iff (!rst_n_q)
    (clk_en && dir_req) |=> (dir_is_sfr_q == $past(dir_addr[7]) && dir_is_ram_q != dir_is_sfr_q);
  endproperty
  a_dir_split: assert property (p_dir_split) else $error("direct split wrong");

  property p_ind_done;
    @(posedge clk_sys) disable iff (!rst_n_q)
    (clk_en && st_q.ind_pend) |=> (ind_vld_q && ind_addr_q == $past(mem_rdata));
  endproperty
  a_ind_done: assert property (p_ind_done) else $error("indirect address late");

  property p_page_tgt;
    @(posedge clk_sys) disable iff (!rst_n_q)
    (clk_en && tgt_req && tgt_kind == crf_pkg::TGT_PAGE)
      |=> (tgt_vld_q && tgt_pc_q[15:11] == $past(next_pc[15:11])
           && tgt_pc_q[10:0] == $past(tgt_off[10:0]));
  endproperty
  a_page_tgt: assert property (p_page_tgt) else $error("page target wrong");

  property p_bank;
    @(posedge clk_sys) disable iff (!rst_n_q)
    bank_q == psw_q[crf_pkg::PSW_BANK_HI:crf_pkg::PSW_BANK_LO];
  endproperty
  a_bank: assert property (p_bank) else $error("bank select mismatch");

endmodule

`default_nettype wire

// file: rtl/crf_pkg.sv
// Constants shared by the core register file and its working-register memory.
// Assumes an 8-bit core whose special function registers sit at 0x80 and above.
`default_nettype none

package crf_pkg;

  // ==========================================================================
  // Special function register byte offsets
  localparam logic [7:0] OFS_STACK_POINTER   = 8'h81;
  localparam logic [7:0] OFS_PTR0_LOW        = 8'h82;
  localparam logic [7:0] OFS_PTR0_HIGH       = 8'h83;
  localparam logic [7:0] OFS_PTR1_LOW        = 8'h84;
  localparam logic [7:0] OFS_PTR1_HIGH       = 8'h85;
  localparam logic [7:0] OFS_POINTER_SELECT  = 8'h92;
  localparam logic [7:0] OFS_STATUS_WORD     = 8'hd0;
  localparam logic [7:0] OFS_ACCUMULATOR     = 8'he0;
  localparam logic [7:0] OFS_MULDIV_OPERAND  = 8'hf0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_STACK_POINTER   = 8'h07;
  localparam logic [7:0] RST_BYTE            = 8'h00;

  // ==========================================================================
  // Status word field positions
  localparam int unsigned PSW_CARRY          = 7;
  localparam int unsigned PSW_NIBBLE_CARRY   = 6;
  localparam int unsigned PSW_USER_ZERO      = 5;
  localparam int unsigned PSW_BANK_HI        = 4;
  localparam int unsigned PSW_BANK_LO        = 3;
  localparam int unsigned PSW_OVERFLOW       = 2;
  localparam int unsigned PSW_USER_ONE       = 1;
  localparam int unsigned PSW_PARITY         = 0;

  // ==========================================================================
  // Working-register banks and address windows
  localparam int unsigned WREG_ADDR_W        = 5;
  localparam int unsigned WREG_DEPTH         = 32;
  localparam logic [15:0] XWIN_FIRST         = 16'hff00;
  localparam logic [15:0] XWIN_LAST          = 16'hff1f;
  localparam logic [7:0]  DIRECT_SFR_FIRST   = 8'h80;
  localparam int unsigned PAGE_BITS          = 11;

  // ==========================================================================
  // Arithmetic flag-update kinds
  localparam logic [1:0] FOP_ADD             = 2'h0;
  localparam logic [1:0] FOP_SUB             = 2'h1;
  localparam logic [1:0] FOP_MULDIV          = 2'h2;
  localparam logic [1:0] FOP_OTHER           = 2'h3;

  // Branch target kinds
  localparam logic [1:0] TGT_PAGE            = 2'h0;
  localparam logic [1:0] TGT_REL             = 2'h1;
  localparam logic [1:0] TGT_LONG            = 2'h2;

endpackage

`default_nettype wire

// file: rtl/crf_wreg_ram.sv
// Memory holding the four banks of eight working registers.
// Assumes the caller arbitrates to one access per cycle; read data is registered.
`timescale 1ns/10ps
`default_nettype none

module crf_wreg_ram (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  input  wire logic                          we,
  input  wire logic [crf_pkg::WREG_ADDR_W-1:0] addr,
  input  wire logic [7:0]                    wdata,
  output logic      [7:0]                    rdata_q
);

  typedef struct packed {
    logic [crf_pkg::WREG_DEPTH-1:0][7:0] mem;
    logic [7:0]                          rdata;
  } crf_ram_state_t;

  crf_ram_state_t st_q;
  crf_ram_state_t st_d;

  // ==========================================================================
  // Next state: write or registered read
  always_comb begin
    st_d = st_q;
    if (we) begin
      st_d.mem[addr] = wdata;
    end else begin
      st_d.rdata = st_q.mem[addr];
    end
  end

  // Cleared at reset so simulation never reads unknown register contents
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign rdata_q = st_q.rdata;

endmodule

`default_nettype wire

// file: testbench/crf_datamem_model.sv
// Data memory model seen by the stack outputs of the register file.
// Assumes stack strobes are one-cycle pulses with address and data held after.
`timescale 1ns/10ps
`default_nettype none

module crf_datamem_model (
  input  wire logic       clk_sys,
  input  wire logic       stk_wr_q,
  input  wire logic       stk_rd_q,
  input  wire logic [7:0] stk_addr_q,
  input  wire logic [7:0] stk_data_q,
  output logic      [7:0] pop_data
);
  // ==========================================================================
  // Storage
  logic [7:0] mem [256];
  logic [7:0] last_q;

  // Store at the address already bumped by the push; no reset, like real memory
  always_ff @(posedge clk_sys) begin
    if (stk_wr_q) begin
      mem[stk_addr_q] <= stk_data_q;
    end
    if (stk_rd_q) begin
      last_q <= mem[stk_addr_q];
    end
  end

  // Outside a pop the lines flip, so a stale byte can never pass as good data
  assign pop_data = stk_rd_q ? mem[stk_addr_q] : ~last_q;
endmodule
`default_nettype wire

// file: testbench/cpu_core_register_file_test.sv
// Self-checking bench for the core register set, driven as the datapath would.
// Assumes crf_pkg and crf_top are compiled first; one 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module cpu_core_register_file_test;
  // ==========================================================================
  // Signals
  logic        clk_sys, nrst, clk_en, sfr_rd, sfr_wr, sfr_bit_wr, sfr_bit_val;
  logic        acc_wr, b_wr, flag_upd, flag_cy, flag_ac, flag_ov, ptr_load, ptr_inc;
  logic        push, pop, wreg_rd, wreg_wr, xd_req, xd_wr, ind_req, ind_sel, dir_req;
  logic        tgt_req, ram_rvld_q, ind_vld_q, dir_is_sfr_q, dir_is_ram_q;
  logic        stk_wr_q, stk_rd_q, tgt_vld_q;
  logic [1:0]  flag_op, tgt_kind, bank_q;
  logic [2:0]  sfr_bit_idx, wreg_idx;
  logic [7:0]  sfr_addr, sfr_wdata, acc_wdata, b_wdata, push_data, wreg_wdata;
  logic [7:0]  xd_wdata, dir_addr, sfr_rdata_q, ram_rdata_q, psw_q, acc_q, b_q;
  logic [7:0]  sp_q, ind_addr_q, dir_addr_q, stk_addr_q, stk_data_q, pop_data;
  logic [15:0] ptr_load_val, xd_addr, next_pc, tgt_off, dptr_q, tgt_pc_q;
  int          fail_count;
  int          checks;
  logic [7:0]  ofs [10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h92, 8'hd0, 8'he0,
                            8'hf0, 8'h80};
  logic [1:0]  fop [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
  logic [7:0]  fexp [4] = '{8'hc4, 8'h00, 8'hc4, 8'h04};
  logic [1:0]  tk [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  logic [15:0] np [5] = '{16'h3ffe, 16'h0100, 16'h0100, 16'h1234, 16'h1234};
  logic [15:0] to [5] = '{16'h0123, 16'h00fe, 16'h007f, 16'hbeef, 16'h0042};
  logic [15:0] te [5] = '{16'h3923, 16'h00fe, 16'h017f, 16'hbeef, 16'h0042};

  crf_top i_dut (.clk_sys, .nrst, .clk_en, .sfr_addr, .sfr_rd, .sfr_wr, .sfr_wdata,
    .sfr_bit_wr, .sfr_bit_idx, .sfr_bit_val, .sfr_rdata_q, .acc_wr, .acc_wdata, .b_wr,
    .b_wdata, .flag_upd, .flag_op, .flag_cy, .flag_ac, .flag_ov, .ptr_load,
    .ptr_load_val, .ptr_inc, .push, .push_data, .pop, .wreg_rd, .wreg_wr, .wreg_idx,
    .wreg_wdata, .xd_req, .xd_wr, .xd_addr, .xd_wdata, .ind_req, .ind_sel, .dir_req,
    .dir_addr, .tgt_req, .tgt_kind, .next_pc, .tgt_off, .ram_rdata_q, .ram_rvld_q,
    .dptr_q, .psw_q, .acc_q, .b_q, .sp_q, .bank_q, .ind_addr_q, .ind_vld_q, .dir_addr_q,
    .dir_is_sfr_q, .dir_is_ram_q, .stk_wr_q, .stk_rd_q, .stk_addr_q, .stk_data_q,
    .tgt_pc_q, .tgt_vld_q);

  crf_datamem_model i_mem (.clk_sys, .stk_wr_q, .stk_rd_q, .stk_addr_q, .stk_data_q,
    .pop_data);

  // ==========================================================================
  // Tasks
  // Strobes drop by non-blocking assignment at the launch edge, so the next
  // request can be raised 1 ns later without a second assignment in one step
  task automatic go();
    @(posedge clk_sys);
    {sfr_rd, sfr_wr, sfr_bit_wr, acc_wr, b_wr, flag_upd, ptr_load, ptr_inc, push, pop,
     wreg_rd, wreg_wr, xd_req, ind_req, dir_req, tgt_req} <= '0;
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    go();
  endtask

  task automatic sfr_read(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    go();
    chk({8'h00, sfr_rdata_q}, {8'h00, e});
  endtask

  task automatic done(input string name);
    $display("test %s finished, %0d checks so far", name, checks);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog; the tests need under a hundred cycles
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (3000) @(posedge clk_sys);
    fail_count++;
    $display("watchdog expired at %0t", $time);
    tally_and_finish();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    {sfr_addr, sfr_rd, sfr_wr, sfr_wdata, sfr_bit_wr, sfr_bit_idx, sfr_bit_val, acc_wr,
     acc_wdata, b_wr, b_wdata, flag_upd, flag_op, flag_cy, flag_ac, flag_ov, ptr_load,
     ptr_load_val, ptr_inc, push, push_data, pop, wreg_rd, wreg_wr, wreg_idx, wreg_wdata,
     xd_req, xd_wr, xd_addr, xd_wdata, ind_req, ind_sel, dir_req, dir_addr, tgt_req,
     tgt_kind, next_pc, tgt_off} = '0;
    fail_count = 0;
    checks = 0;
    clk_en = 1'b1;
    nrst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    repeat (3) go();
    // Reset values, the unmapped address last
    for (int i = 0; i < 10; i++) begin
      sfr_read(ofs[i], (i == 0) ? 8'h07 : 8'h00);
    end
    done("reset");
    // First push lands just above the reset pointer, then pops back
    push_data = 8'haa;
    push = 1'b1;
    go();
    chk({sp_q, stk_addr_q}, 16'h0808);
    chk({stk_data_q, 7'h00, stk_wr_q}, 16'haa01);
    pop = 1'b1;
    go();
    chk({sp_q, pop_data}, 16'h07aa);
    chk({stk_addr_q, 7'h00, stk_rd_q}, 16'h0801);
    xd_addr = 16'hff08;
    xd_req = 1'b1;
    go();
    chk({ram_rdata_q, 7'h00, ram_rvld_q}, 16'haa01);
    xd_addr = 16'hff20;
    xd_req = 1'b1;
    go();
    chk({15'h0000, ram_rvld_q}, 16'h0000);
    done("stack");
    // Two pointers, select bit, increment and load of the active one
    sfr_write(8'h83, 8'h12);
    sfr_write(8'h82, 8'h34);
    sfr_write(8'h85, 8'h56);
    sfr_write(8'h84, 8'h78);
    chk(dptr_q, 16'h1234);
    sfr_write(8'h92, 8'hff);
    sfr_read(8'h92, 8'h01);
    chk(dptr_q, 16'h5678);
    ptr_inc = 1'b1;
    go();
    sfr_read(8'h84, 8'h79);
    ptr_load_val = 16'habcd;
    ptr_load = 1'b1;
    go();
    sfr_read(8'h85, 8'hab);
    sfr_read(8'h83, 8'h12);
    done("pointers");
    // Every arithmetic kind with all flag inputs high
    {flag_cy, flag_ac, flag_ov} = 3'h7;
    for (int i = 0; i < 4; i++) begin
      flag_op = fop[i];
      flag_upd = 1'b1;
      go();
      chk({8'h00, psw_q & 8'hc4}, {8'h00, fexp[i]});
    end
    // Parity follows the accumulator whoever writes it
    acc_wdata = 8'h07;
    acc_wr = 1'b1;
    go();
    chk({acc_q, 7'h00, psw_q[0]}, 16'h0701);
    sfr_write(8'he0, 8'h03);
    chk({acc_q, 7'h00, psw_q[0]}, 16'h0300);
    // A write while the clock enable is low must leave everything frozen
    clk_en = 1'b0;
    acc_wdata = 8'hfe;
    acc_wr = 1'b1;
    go();
    chk({acc_q, 7'h00, psw_q[0]}, 16'h0300);
    clk_en = 1'b1;
    b_wdata = 8'h3c;
    b_wr = 1'b1;
    go();
    chk({8'h00, b_q}, 16'h003c);
    sfr_read(8'hf0, 8'h3c);
    done("flags");
    // Status word byte and bit writes, bank select
    sfr_write(8'hd0, 8'h19);
    chk({6'h00, bank_q, psw_q}, 16'h0318);
    sfr_bit_val = 1'b1;
    for (int i = 0; i < 3; i++) begin
      sfr_bit_idx = (i == 0) ? 3'h5 : ((i == 1) ? 3'h1 : 3'h4);
      sfr_bit_val = (i < 2);
      sfr_bit_wr = 1'b1;
      go();
    end
    sfr_read(8'hd0, 8'h2a);
    chk({14'h0000, bank_q}, 16'h0001);
    // Working registers of bank 1 through all three routes
    wreg_idx = 3'h1;
    wreg_wdata = 8'h5a;
    wreg_wr = 1'b1;
    go();
    xd_addr = 16'hff09;
    xd_req = 1'b1;
    go();
    chk({ram_rdata_q, 7'h00, ram_rvld_q}, 16'h5a01);
    ind_sel = 1'b1;
    ind_req = 1'b1;
    go();
    go();
    chk({ind_addr_q, 7'h00, ind_vld_q}, 16'h5a01);
    // Write through the window, read back as a bank 1 register
    xd_addr = 16'hff0a;
    xd_wdata = 8'hc3;
    xd_wr = 1'b1;
    xd_req = 1'b1;
    go();
    wreg_idx = 3'h2;
    wreg_rd = 1'b1;
    go();
    chk({ram_rdata_q, 7'h00, ram_rvld_q}, 16'hc301);
    wreg_idx = 3'h1;
    sfr_write(8'hd0, 8'h00);
    wreg_rd = 1'b1;
    go();
    chk({ram_rdata_q, 7'h00, ram_rvld_q}, 16'h0001);
    done("banks");
    // Direct address split and branch target forms
    for (int i = 0; i < 2; i++) begin
      dir_addr = 8'h7f + 8'(i);
      dir_req = 1'b1;
      go();
      chk({dir_addr_q, 6'h00, dir_is_sfr_q, dir_is_ram_q},
          {dir_addr, 6'h00, 2'(i + 1)});
    end
    for (int i = 0; i < 5; i++) begin
      tgt_kind = tk[i];
      next_pc = np[i];
      tgt_off = to[i];
      tgt_req = 1'b1;
      go();
      chk(tgt_pc_q, te[i]);
      chk({15'h0000, tgt_vld_q}, 16'h0001);
    end
    done("addressing");
    tally_and_finish();
  end
endmodule
`default_nettype wire
